//--- hdl/fsq_pkg.sv
package fsq_pkg;
    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int ADDR_W = 6;
    localparam int SECT_W = 2;
    localparam int SECT_N = 4;
    localparam int TMR_W = 13;
    localparam int PULSE_W = 4;

    // ************************************************************
    // Command codes
    // ************************************************************
    localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_PROGRAM = 8'hA0;
    localparam logic [7:0] CMD_BYPASS = 8'h20;
    localparam logic [7:0] CMD_BYP_EXIT1 = 8'h90;
    localparam logic [7:0] CMD_BYP_EXIT2 = 8'h00;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_BULK = 8'h10;
    localparam logic [7:0] CMD_SECTOR = 8'h30;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 6'h15;
    localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 6'h2A;

    // ************************************************************
    // Data values and status bit positions
    // ************************************************************
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ERASED = 8'hFF;
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int ERROR_BIT = 5;
    localparam int WINDOW_BIT = 3;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_MHZ = 40;
    localparam int WINDOW_US = 100;
    localparam logic [TMR_W-1:0] WINDOW_CYCLES = TMR_W'(WINDOW_US * CLK_MHZ);
    localparam logic [TMR_W-1:0] PROG_CYCLES = 13'h0010;
    localparam logic [PULSE_W-1:0] MAX_PULSES = 4'h8;

    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [3:0] {
        S_READ, S_C1, S_C2, S_E3, S_E4, S_E5, S_PROG_WAIT, S_PROG_BUSY,
        S_BYP, S_BYP_PROG, S_BYP_EXIT, S_WIN, S_EBUSY, S_SUSP, S_FAIL
    } fsq_state_t;
endpackage : fsq_pkg

//--- hdl/fsq_timer.sv
`timescale 1ns/1ps
module fsq_timer #(
    parameter int W = 13
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic done
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } fsq_tmr_t;

    fsq_tmr_t r;
    fsq_tmr_t d;

    // ************************************************************
    // Down counter, reload restarts from full count
    // ************************************************************
    always_comb begin
        d = r;
        if (load) begin
            d.cnt = value;
        end else if (r.cnt != '0) begin
            d.cnt = r.cnt - 1'b1;
        end
    end

    assign done = !load && (r.cnt == W'(1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= d;
        end
    end
endmodule : fsq_timer

//--- hdl/fsq_array.sv
`timescale 1ns/1ps
module fsq_array #(
    parameter int AW = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata
);
    import fsq_pkg::*;

    logic [7:0] mem [0:(1<<AW)-1];

    // ************************************************************
    // Byte array, erased after reset
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < (1 << AW); i++) begin
                mem[i] <= BYTE_ERASED;
            end
        end else if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];
endmodule : fsq_array

//--- hdl/fsq_flash_seq.sv
`timescale 1ns/1ps
module fsq_flash_seq
    import fsq_pkg::*;
#(
    parameter logic [ADDR_W-1:0] U1_ADDR = UNLOCK1_ADDR,
    parameter logic [ADDR_W-1:0] U2_ADDR = UNLOCK2_ADDR,
    parameter logic [7:0] U1_DATA = CMD_UNLOCK1,
    parameter logic [7:0] U2_DATA = CMD_UNLOCK2,
    parameter logic [7:0] ERASE_CODE = CMD_ERASE_SETUP,
    parameter logic [7:0] BULK_CODE = CMD_BULK,
    parameter logic [7:0] SECTOR_CODE = CMD_SECTOR,
    parameter logic [TMR_W-1:0] WIN_CYCLES = WINDOW_CYCLES,
    parameter logic [TMR_W-1:0] PGM_CYCLES = PROG_CYCLES,
    parameter logic [PULSE_W-1:0] PULSE_LIMIT = MAX_PULSES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic main_sector_select,
    input wire logic secondary_sector_select,
    input wire logic array_fault
);
    import fsq_pkg::*;

    typedef struct packed {
        fsq_state_t state;
        logic byp;
        logic tog;
        logic err;
        logic ers;
        logic bulk;
        logic phase;
        logic [ADDR_W-1:0] tgt_addr;
        logic [7:0] tgt_data;
        logic [SECT_N-1:0] smask;
        logic [ADDR_W-1:0] ptr;
        logic [PULSE_W-1:0] pulses;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } fsq_regs_t;

    fsq_regs_t r;
    fsq_regs_t d;

    logic acc;
    logic rd_phase;
    logic in_range;
    logic wr;
    logic sel_act;
    logic stat_loc;
    logic last_step;
    logic [7:0] cmd;
    logic [ADDR_W-1:0] fa;
    logic [SECT_W-1:0] sec;
    logic [SECT_N-1:0] onehot;
    logic [7:0] status;
    logic [7:0] arr_rdata;
    logic arr_we;
    logic [ADDR_W-1:0] arr_waddr;
    logic [7:0] arr_wdata;
    logic tmr_load;
    logic [TMR_W-1:0] tmr_value;
    logic tmr_done;
    logic ptr_in_set;

    // ************************************************************
    // Submodules
    // ************************************************************
    fsq_array #(.AW(ADDR_W)) u_array (
        .pclk(pclk),
        .presetn(presetn),
        .we(arr_we),
        .waddr(arr_waddr),
        .wdata(arr_wdata),
        .raddr(fa),
        .rdata(arr_rdata)
    );

    fsq_timer #(.W(TMR_W)) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .load(tmr_load),
        .value(tmr_value),
        .done(tmr_done)
    );

    // ************************************************************
    // Bus decode and status byte
    // ************************************************************
    assign acc = psel && penable && r.ready;
    assign rd_phase = psel && penable && !r.ready;
    assign in_range = (paddr[31:ADDR_W+2] == '0);
    assign wr = acc && pwrite && in_range && pstrb[0];
    assign cmd = pwdata[7:0];
    assign fa = paddr[ADDR_W+1:2];
    assign sec = fa[ADDR_W-1 -: SECT_W];
    assign sel_act = main_sector_select || secondary_sector_select;
    assign ptr_in_set = r.bulk || r.smask[r.ptr[ADDR_W-1 -: SECT_W]];
    assign last_step = (r.state == S_EBUSY) && r.phase && (r.ptr == '1);

    always_comb begin
        onehot = '0;
        onehot[sec] = 1'b1;
        stat_loc = 1'b0;
        if ((r.state == S_PROG_BUSY || r.state == S_FAIL) && !r.ers && fa == r.tgt_addr) begin
            stat_loc = 1'b1;
        end
        if ((r.state == S_WIN || r.state == S_EBUSY || r.state == S_FAIL) && r.ers &&
            (r.bulk || r.smask[sec])) begin
            stat_loc = 1'b1;
        end
        status = '0;
        status[POLL_BIT] = r.ers ? 1'b0 : ~r.tgt_data[7];
        status[TOGGLE_BIT] = r.tog;
        status[ERROR_BIT] = r.err;
        status[WINDOW_BIT] = r.ers && (r.state != S_WIN);
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb begin
        d = r;
        arr_we = 1'b0;
        arr_waddr = r.ptr;
        arr_wdata = BYTE_ZERO;
        tmr_load = 1'b0;
        tmr_value = PGM_CYCLES;
        d.ready = rd_phase;
        if (rd_phase) begin
            d.slverr = !in_range;
            d.rdata = '0;
            if (in_range) begin
                d.rdata[7:0] = stat_loc ? status : arr_rdata;
            end
        end
        if (acc && !pwrite && in_range && stat_loc) begin
            d.tog = ~r.tog;
        end
        case (r.state)
            S_READ: begin
                if (wr && fa == U1_ADDR && cmd == U1_DATA) begin
                    d.state = S_C1;
                end
            end
            S_C1: begin
                if (wr) begin
                    d.state = (fa == U2_ADDR && cmd == U2_DATA) ? S_C2 : S_READ;
                end
            end
            S_C2: begin
                if (wr) begin
                    d.state = S_READ;
                    if (fa == U1_ADDR && cmd == CMD_PROGRAM) begin
                        d.state = S_PROG_WAIT;
                    end else if (fa == U1_ADDR && cmd == CMD_BYPASS) begin
                        d.state = S_BYP;
                        d.byp = 1'b1;
                    end else if (fa == U1_ADDR && cmd == ERASE_CODE) begin
                        d.state = S_E3;
                    end
                end
            end
            S_E3: begin
                if (wr) begin
                    d.state = (fa == U1_ADDR && cmd == U1_DATA) ? S_E4 : S_READ;
                end
            end
            S_E4: begin
                if (wr) begin
                    d.state = (fa == U2_ADDR && cmd == U2_DATA) ? S_E5 : S_READ;
                end
            end
            S_E5: begin
                if (wr) begin
                    d.state = S_READ;
                    d.err = 1'b0;
                    d.ptr = '0;
                    d.phase = 1'b0;
                    d.pulses = '0;
                    if (fa == U1_ADDR && cmd == BULK_CODE) begin
                        d.state = S_EBUSY;
                        d.ers = 1'b1;
                        d.bulk = 1'b1;
                        d.smask = '1;
                    end else if (cmd == SECTOR_CODE) begin
                        d.state = S_WIN;
                        d.ers = 1'b1;
                        d.bulk = 1'b0;
                        d.smask = onehot;
                        tmr_load = 1'b1;
                        tmr_value = WIN_CYCLES;
                    end
                end
            end
            S_PROG_WAIT, S_BYP_PROG: begin
                if (wr) begin
                    d.tgt_addr = fa;
                    d.tgt_data = cmd;
                    d.ers = 1'b0;
                    d.bulk = 1'b0;
                    d.pulses = '0;
                    if ((cmd & ~arr_rdata) != '0) begin
                        d.err = 1'b1;
                        d.state = S_FAIL;
                    end else begin
                        d.err = 1'b0;
                        d.state = S_PROG_BUSY;
                        tmr_load = 1'b1;
                    end
                end
            end
            S_PROG_BUSY: begin
                if (tmr_done) begin
                    if (array_fault) begin
                        if (r.pulses == PULSE_LIMIT - 1'b1) begin
                            d.err = 1'b1;
                            d.state = S_FAIL;
                        end else begin
                            d.pulses = r.pulses + 1'b1;
                            tmr_load = 1'b1;
                        end
                    end else begin
                        arr_we = 1'b1;
                        arr_waddr = r.tgt_addr;
                        arr_wdata = r.tgt_data;
                        d.state = r.byp ? S_BYP : S_READ;
                    end
                end
            end
            S_BYP: begin
                if (wr && cmd == CMD_PROGRAM) begin
                    d.state = S_BYP_PROG;
                end else if (wr && cmd == CMD_BYP_EXIT1) begin
                    d.state = S_BYP_EXIT;
                end
            end
            S_BYP_EXIT: begin
                if (wr) begin
                    d.state = (cmd == CMD_BYP_EXIT2) ? S_READ : S_BYP;
                    d.byp = (cmd != CMD_BYP_EXIT2);
                end
            end
            S_WIN: begin
                if (wr) begin
                    if (cmd == SECTOR_CODE) begin
                        d.smask = r.smask | onehot;
                        tmr_load = 1'b1;
                        tmr_value = WIN_CYCLES;
                    end else if (cmd == CMD_SUSPEND && sel_act) begin
                        d.state = S_SUSP;
                    end else begin
                        d.state = S_READ;
                        d.smask = '0;
                        d.ers = 1'b0;
                    end
                end else if (tmr_done) begin
                    d.state = S_EBUSY;
                end
            end
            S_EBUSY: begin
                if (wr && !r.bulk && cmd == CMD_RESET) begin
                    d.state = S_READ;
                    d.smask = '0;
                    d.ers = 1'b0;
                end else if (wr && !r.bulk && cmd == CMD_SUSPEND && sel_act) begin
                    d.state = S_SUSP;
                end else if (ptr_in_set && array_fault) begin
                    if (r.pulses == PULSE_LIMIT - 1'b1) begin
                        d.err = 1'b1;
                        d.state = S_FAIL;
                    end else begin
                        d.pulses = r.pulses + 1'b1;
                    end
                end else begin
                    arr_we = ptr_in_set;
                    arr_wdata = r.phase ? BYTE_ERASED : BYTE_ZERO;
                    d.pulses = '0;
                    d.ptr = r.ptr + 1'b1;
                    if (r.ptr == '1) begin
                        d.phase = 1'b1;
                        if (r.phase) begin
                            d.state = S_READ;
                            d.smask = '0;
                            d.ers = 1'b0;
                            d.bulk = 1'b0;
                        end
                    end
                end
            end
            S_SUSP: begin
                if (wr && cmd == CMD_RESUME && sel_act) begin
                    d.state = S_EBUSY;
                end else if (wr && cmd == CMD_RESET) begin
                    d.state = S_READ;
                    d.smask = '0;
                    d.ers = 1'b0;
                end
            end
            S_FAIL: begin
                if (wr && cmd == CMD_RESET) begin
                    d.state = S_READ;
                    d.err = 1'b0;
                    d.byp = 1'b0;
                    d.ers = 1'b0;
                    d.bulk = 1'b0;
                    d.smask = '0;
                end
            end
            default: begin
                d.state = S_READ;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= d;
        end
    end

    assign prdata = r.rdata;
    assign pready = r.ready;
    assign pslverr = r.slverr;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_PROG_TOGGLE: assert property (
        acc && !pwrite && in_range && r.state == S_PROG_BUSY && fa == r.tgt_addr |=> r.tog != $past(r.tog))
        else $error("toggle bit did not advance on program status read");
    AST_READ_STABLE: assert property (
        r.state == S_READ && acc && !pwrite |=> $stable(r.tog))
        else $error("toggle bit moved in array read mode");
    AST_ZERO_TO_ONE: assert property (
        wr && r.state == S_PROG_WAIT && (cmd & ~arr_rdata) != '0 |=> r.err && r.state == S_FAIL)
        else $error("zero to one program did not flag error");
    AST_ERASE_STATUS: assert property (
        rd_phase && in_range && r.state == S_EBUSY && r.smask[sec] |=>
        prdata[TOGGLE_BIT] == $past(r.tog) && !prdata[POLL_BIT] && pready)
        else $error("erase status not returned in erasing sector");
    AST_BYPASS_IGNORE: assert property (
        wr && r.state == S_BYP && cmd != CMD_PROGRAM && cmd != CMD_BYP_EXIT1 |=> r.state == S_BYP)
        else $error("bypass mode reacted to a foreign command");
    AST_BYPASS_EXIT: assert property (
        wr && r.state == S_BYP_EXIT && cmd == CMD_BYP_EXIT2 |=> r.state == S_READ && !r.byp)
        else $error("bypass exit did not return to read");
    AST_BULK_LOCK: assert property (
        wr && r.state == S_EBUSY && r.bulk && !last_step && !array_fault |=> r.state == S_EBUSY)
        else $error("bulk erase accepted a command");
    AST_WIN_RESTART: assert property (
        wr && r.state == S_WIN && cmd == SECTOR_CODE |=> !tmr_done [*8])
        else $error("window not restarted by extra confirm");
    AST_WIN_ABORT: assert property (
        wr && r.state == S_WIN && cmd != SECTOR_CODE && cmd != CMD_SUSPEND |=> r.state == S_READ)
        else $error("foreign command did not abort the window");
    AST_SUSPEND: assert property (
        wr && r.state == S_EBUSY && !r.bulk && cmd == CMD_SUSPEND && sel_act |=> r.state == S_SUSP)
        else $error("suspend not taken");
    AST_PREPROGRAM: assert property (
        r.state == S_EBUSY && arr_we && !r.phase |-> arr_wdata == BYTE_ZERO)
        else $error("preprogram pass wrote a nonzero byte");
endmodule : fsq_flash_seq

//--- tb/fsq_host_model.sv
`timescale 1ns/1ps
// ****
// Byte-wide host issuing bus cycles
// ****
module fsq_host_model (
    input wire logic pclk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb
);
    logic [7:0] rd_q;
    logic err_q;
    initial begin
        err_q = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        rd_q = 8'h00;
    end
    // One byte per word access, held until pready
    task automatic xfer(input logic wr, input logic [6:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {23'h0, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) fsq_flash_seq_tb.end_sim(1);
        rd_q = prdata[7:0];
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~pwdata;
        @(posedge pclk);
    endtask : xfer
endmodule : fsq_host_model

//--- tb/fsq_flash_seq_tb.sv
`timescale 1ns/1ps
module fsq_flash_seq_tb;
    import fsq_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fault, sel;
    logic [31:0] paddr, pwdata, prdata;
    logic [3:0] pstrb;
    logic [7:0] s, t;
    int n_fail = 0;
    int comparisons = 0;
    fsq_flash_seq #(.WIN_CYCLES(13'h0014)) i_fsq_flash_seq (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .main_sector_select(sel), .secondary_sector_select(1'b0),
        .array_fault(fault));
    fsq_host_model i_fsq_host_model (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // ****
    // Helpers
    // ****
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic end_sim(input int tmo);
        if (tmo != 0) n_fail++;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        i_fsq_host_model.xfer(1'b1, {1'b0, a}, d);
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        i_fsq_host_model.xfer(1'b0, {1'b0, a}, 8'h00);
        d = i_fsq_host_model.rd_q;
    endtask : rd
    task automatic cmd(input logic [7:0] c);
        wr(UNLOCK1_ADDR, CMD_UNLOCK1);
        wr(UNLOCK2_ADDR, CMD_UNLOCK2);
        wr(UNLOCK1_ADDR, c);
    endtask : cmd
    task automatic erase(input logic [5:0] a, input logic [7:0] c);
        cmd(CMD_ERASE_SETUP);
        wr(UNLOCK1_ADDR, CMD_UNLOCK1);
        wr(UNLOCK2_ADDR, CMD_UNLOCK2);
        wr(a, c);
    endtask : erase
    task automatic wait_done(input logic [5:0] a, output logic [7:0] d);
        logic [7:0] p;
        int n;
        rd(a, p);
        for (n = 0; n < 3000; n++) begin
            rd(a, d);
            if (p[6] === d[6]) break;
            p = d;
        end
        if (n >= 3000) end_sim(1);
    endtask : wait_done
    // ****
    // Scenarios
    // ****
    task automatic t_program;
        cmd(CMD_PROGRAM);
        wr(6'h03, 8'h5A);
        rd(6'h03, s);
        rd(6'h03, t);
        check(s & 8'hA8, 8'h80);
        check((s ^ t) & 8'h40, 8'h40);
        wait_done(6'h03, s);
        check(s, 8'h5A);
        rd(6'h03, t);
        check(t, 8'h5A);
        cmd(CMD_PROGRAM);
        wr(6'h03, 8'hFF);
        rd(6'h03, s);
        check(s & 8'h20, 8'h20);
        rd(6'h03, t);
        check((s ^ t) & 8'h40, 8'h40);
        wr(6'h00, CMD_RESET);
        rd(6'h03, s);
        check(s, 8'h5A);
        check({7'h00, i_fsq_host_model.err_q}, 8'h00);
        i_fsq_host_model.xfer(1'b0, 7'h40, 8'h00);
        check({7'h00, i_fsq_host_model.err_q}, 8'h01);
        check(i_fsq_host_model.rd_q, 8'h00);
    endtask : t_program
    task automatic t_bypass;
        cmd(CMD_BYPASS);
        wr(6'h00, CMD_PROGRAM);
        wr(6'h08, 8'h3C);
        wait_done(6'h08, s);
        check(s, 8'h3C);
        wr(UNLOCK1_ADDR, CMD_ERASE_SETUP);
        wr(6'h00, CMD_PROGRAM);
        wr(6'h21, 8'hC3);
        wait_done(6'h21, s);
        check(s, 8'hC3);
        wr(6'h30, CMD_BYP_EXIT1);
        wr(6'h11, CMD_BYP_EXIT2);
        wr(6'h00, CMD_PROGRAM);
        wr(6'h0A, 8'h00);
        rd(6'h0A, s);
        check(s, 8'hFF);
    endtask : t_bypass
    task automatic t_sector;
        erase(6'h10, CMD_SECTOR);
        wr(6'h00, CMD_PROGRAM);
        rd(6'h12, s);
        check(s, 8'hFF);
        erase(6'h10, CMD_SECTOR);
        rd(6'h12, s);
        check(s & 8'h88, 8'h00);
        wr(6'h20, CMD_SECTOR);
        repeat (4) rd(6'h12, s);
        check(s & 8'h08, 8'h00);
        wait_done(6'h1F, s);
        rd(6'h21, s);
        check(s, 8'hFF);
        rd(6'h03, s);
        check(s, 8'h5A);
    endtask : t_sector
    task automatic t_suspend;
        cmd(CMD_PROGRAM);
        wr(6'h31, 8'h96);
        wait_done(6'h31, s);
        erase(6'h30, CMD_SECTOR);
        repeat (6) rd(6'h31, s);
        check(s & 8'h88, 8'h08);
        sel <= 1'b0;
        wr(6'h00, CMD_SUSPEND);
        rd(6'h31, s);
        rd(6'h31, t);
        check((s ^ t) & 8'h40, 8'h40);
        sel <= 1'b1;
        wr(6'h00, CMD_SUSPEND);
        rd(6'h31, s);
        rd(6'h31, t);
        check((s ^ t) & 8'h40, 8'h00);
        rd(6'h03, s);
        check(s, 8'h5A);
        wr(6'h00, CMD_RESUME);
        wait_done(6'h31, s);
        check(s, 8'hFF);
        erase(6'h30, CMD_SECTOR);
        repeat (6) rd(6'h31, s);
        wr(UNLOCK1_ADDR, CMD_UNLOCK1);
        rd(6'h31, s);
        rd(6'h31, t);
        check((s ^ t) & 8'h40, 8'h40);
        wr(6'h00, CMD_RESET);
        rd(6'h31, s);
        check(s, 8'hFF);
    endtask : t_suspend
    task automatic t_bulk;
        int n;
        erase(UNLOCK1_ADDR, 8'h11);
        rd(6'h03, s);
        check(s, 8'h5A);
        fault <= 1'b1;
        erase(UNLOCK1_ADDR, CMD_BULK);
        wr(6'h00, CMD_RESET);
        rd(6'h3F, s);
        rd(6'h3F, t);
        check((s ^ t) & 8'h40, 8'h40);
        for (n = 0; n < 3000 && s[5] !== 1'b1; n++) rd(6'h03, s);
        if (n >= 3000) end_sim(1);
        check(s & 8'h20, 8'h20);
        fault <= 1'b0;
        wr(6'h00, CMD_RESET);
        erase(UNLOCK1_ADDR, CMD_BULK);
        wr(6'h00, CMD_RESET);
        wait_done(6'h03, s);
        check(s, 8'hFF);
        rd(6'h08, s);
        check(s, 8'hFF);
    endtask : t_bulk
    initial begin
        presetn = 1'b0;
        fault = 1'b0;
        sel = 1'b1;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_program();
        t_bypass();
        t_sector();
        t_suspend();
        t_bulk();
        end_sim(0);
    end
endmodule : fsq_flash_seq_tb
